// file: tcs_bank.sv
// Purpose: Transmit gain/clamp, coefficient loading and status flag register bank.
// Assumes: Control port strobes are synchronous one-cycle pulses on ref_clk_in.
// Notes:   Reads return data on rd_data_out one cycle after rd_en_in.
`timescale 1ns/1ps
`include "tcs_params.svh"
module tcs_bank
	import tcs_pkg::*;
(
	input  wire logic         ref_clk_in,
	input  wire logic         srst_in,
	input  wire logic         ce_in,
	input  wire logic [7:0]   reg_addr_in,
	input  wire logic         wr_en_in,
	input  wire logic [15:0]  wr_data_in,
	input  wire logic         rd_en_in,
	input  wire logic [1:0]   sample_tick_in,
	input  wire logic [1:0]   new_data_valid_in,
	input  wire logic [31:0]  new_data_in,
	input  wire logic [1:0]   sat_in,
	input  wire logic [13:0]  coef_rd_addr_in,
	output logic [7:0]        rd_data_out,
	output logic              rd_valid_out,
	output logic [31:0]       sample_out,
	output logic [31:0]       coef_out,
	output logic [1:0]        out_drive_out,
	output logic [1:0]        out_midrail_out,
	output logic [11:0]       gain_out,
	output logic [1:0]        mute_out,
	output logic [1:0]        clear_busy_out,
	output logic              tx_summary_out
);
	tcs_state_t s_reg;
	tcs_state_t s_next;

	// Per-channel three-bit status field: overflow, underrun, idle
	function automatic logic [7:0] pack_status(input logic [1:0] ovf, input logic [1:0] und,
		input logic [1:0] idl);
		pack_status = {1'b0, ovf[1], und[1], idl[1], 1'b0, ovf[0], und[0], idl[0]};
	endfunction

	// Bit position of a per-channel control field
	function automatic int unsigned chan_bit(input int unsigned ch, input int unsigned a,
		input int unsigned b);
		chan_bit = (ch == 0) ? a : b;
	endfunction

	// Next-state logic for the whole bank
	always_comb
	begin
		logic [7:0] status_now;
		status_now = pack_status(s_reg.ovf, s_reg.und, s_reg.idle);
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		// Register writes; reserved gain and status-enable bits are masked off, control bits are stored as written
		if (wr_en_in)
		begin
			unique case (reg_addr_in)
				`TCS_OFF_CHAN_CTRL: s_next.ctrl = wr_data_in;
				`TCS_OFF_GAIN: s_next.gain = wr_data_in & `TCS_GAIN_WMASK;
				`TCS_OFF_COEFF0:
				begin
					s_next.ram0[s_reg.ptr] = wr_data_in;
					s_next.ptr = s_reg.ptr + 7'h01;
				end
				`TCS_OFF_COEFF1:
				begin
					s_next.ram1[s_reg.ptr] = wr_data_in;
					s_next.ptr = s_reg.ptr + 7'h01;
				end
				`TCS_OFF_POINTER: s_next.ptr = wr_data_in[6:0];
				`TCS_OFF_STAT_EN: s_next.stat_en = wr_data_in[7:0] & `TCS_STAT_EN_WMASK;
				default: ;
			endcase
		end
		// Reads; only status answers, write-only and unmapped offsets read zero
		if (rd_en_in)
		begin
			s_next.rd_valid = 1'b1;
			s_next.rd_data = 8'h00;
			if (reg_addr_in == `TCS_OFF_STATUS)
			begin
				s_next.rd_data = status_now;
				s_next.ovf = 2'b00;
				s_next.und = 2'b00;
			end
		end
		// Per-channel event, datapath and idle sequencing; sets come after clears so they win
		for (int unsigned c = 0; c < 2; c++)
		begin
			logic en;
			logic ana;
			logic clamp;
			logic starve;
			logic [6:0] ra;
			en = s_reg.ctrl[chan_bit(c, `TCS_DIG_A, `TCS_DIG_B)];
			ana = s_reg.ctrl[chan_bit(c, `TCS_ANA_A, `TCS_ANA_B)];
			clamp = s_reg.gain[chan_bit(c, `TCS_CLAMP_A, `TCS_CLAMP_B)];
			starve = sample_tick_in[c] && !new_data_valid_in[c];
			ra = coef_rd_addr_in[c*7 +: 7];
			if (sat_in[c])
				s_next.ovf[c] = 1'b1;
			if (sample_tick_in[c] && new_data_valid_in[c])
				s_next.sample[c] = new_data_in[c*16 +: 16];
			if (starve)
				s_next.und[c] = 1'b1; // sample held, so the old word repeats
			unique case (s_reg.st[c])
				TCS_IDLE:
					if (en)
						s_next.st[c] = TCS_RUN;
				TCS_RUN:
					if (!en)
						s_next.st[c] = TCS_DRAIN;
				TCS_DRAIN:
					if (en)
						s_next.st[c] = TCS_RUN;
					else if (starve)
					begin
						s_next.st[c] = TCS_CLEAR;
						s_next.cnt[c] = 8'h00;
					end
				TCS_CLEAR:
				begin
					s_next.cnt[c] = s_reg.cnt[c] + 8'h01;
					s_next.sample[c] = 16'h0000;
					if (s_reg.cnt[c] == `TCS_CLEAR_CYCLES - 8'h01)
						s_next.st[c] = TCS_IDLE;
				end
			endcase
			s_next.idle[c] = (s_next.st[c] == TCS_IDLE);
			s_next.busy[c] = (s_next.st[c] == TCS_CLEAR);
			// Address zero holds the tap for the newest upsampled sample
			s_next.coef[c] = s_reg.ctrl[chan_bit(c, `TCS_SEL_A, `TCS_SEL_B)] ?
				s_reg.ram1[ra] : s_reg.ram0[ra];
			s_next.drive[c] = ana | clamp;
			s_next.midrail[c] = !ana & clamp;
			s_next.gain_o[c] = s_reg.gain[chan_bit(c, `TCS_GAIN_LSB_A, `TCS_GAIN_LSB_B) +: 6];
			s_next.mute[c] = (s_next.gain_o[c] == `TCS_MUTE_CODE);
		end
		// Summary follows the flags live, so it falls once nothing enabled stays high
		s_next.summary = |(s_next.stat_en &
			pack_status(s_next.ovf, s_next.und, s_next.idle));
	end

	// Single state register; clock enable freezes everything
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			s_reg <= '0;
			s_reg.st[0] <= TCS_IDLE;
			s_reg.st[1] <= TCS_IDLE;
			s_reg.idle <= 2'b11; // status resets to 0x11
		end
		else if (ce_in)
			s_reg <= s_next;
	end

	assign rd_data_out = s_reg.rd_data;
	assign rd_valid_out = s_reg.rd_valid;
	assign sample_out = s_reg.sample;
	assign coef_out = s_reg.coef;
	assign out_drive_out = s_reg.drive;
	assign out_midrail_out = s_reg.midrail;
	assign gain_out = s_reg.gain_o;
	assign mute_out = s_reg.mute;
	assign clear_busy_out = s_reg.busy;
	assign tx_summary_out = s_reg.summary;

	// Checks on the bank behaviour; all sample on the system clock and sleep in reset
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	// Status read taken this cycle, shared by the flag checks
	logic status_rd;
	assign status_rd = ce_in && rd_en_in && (reg_addr_in == `TCS_OFF_STATUS);

	// Reset leaves both channels idle, flags clear and the pointer at zero
	reset_state_a: assert property (
		$fell(srst_in) |-> s_reg.idle == 2'b11 && s_reg.ovf == 2'b00 &&
		s_reg.und == 2'b00 && s_reg.ptr == 7'h00)
		else $error("State after reset is not the idle status value");

	// A low clock enable must freeze every bit of state, strobes included
	ce_freeze_a: assert property (
		!ce_in |=> $stable(s_reg))
		else $error("State moved while the clock enable was low");

	// Every coefficient write lands at the pointer and moves it on by one; 127 wraps to 0
	ptr_advance_a: assert property (
		ce_in && wr_en_in &&
		(reg_addr_in == `TCS_OFF_COEFF0 || reg_addr_in == `TCS_OFF_COEFF1) |=>
		s_reg.ptr == $past(s_reg.ptr) + 7'h01)
		else $error("Pointer did not advance after coefficient write");

	coeff_store_a: assert property (
		ce_in && wr_en_in && reg_addr_in == `TCS_OFF_COEFF0 |=>
		s_reg.ram0[$past(s_reg.ptr)] == $past(wr_data_in))
		else $error("Coefficient word not stored at pointer");

	coeff_bank1_a: assert property (
		ce_in && wr_en_in && reg_addr_in == `TCS_OFF_COEFF1 |=>
		s_reg.ram1[$past(s_reg.ptr)] == $past(wr_data_in))
		else $error("Second memory word not stored at pointer");

	// Pointer writes keep only the seven address bits
	ptr_load_a: assert property (
		ce_in && wr_en_in && reg_addr_in == `TCS_OFF_POINTER |=>
		s_reg.ptr == $past(wr_data_in[6:0]))
		else $error("Pointer write not taken");

	// Saturation sets the overflow flag and only a status read clears it
	ovf_sticky_a: assert property (
		ce_in && sat_in[0] |=> s_reg.ovf[0])
		else $error("Overflow event lost");

	ovf_hold_a: assert property (
		ce_in && s_reg.ovf[0] && !status_rd |=> s_reg.ovf[0])
		else $error("Overflow flag cleared without a status read");

	ovf_clear_a: assert property (
		status_rd && !sat_in[1] |=> !s_reg.ovf[1])
		else $error("Status read did not clear overflow");

	// Underrun sets on a starved tick, holds the old word and clears on a status read
	und_hold_a: assert property (
		ce_in && sample_tick_in[1] && !new_data_valid_in[1] |=>
		(s_reg.und[1] && $stable(s_reg.sample[1])) || s_reg.busy[1])
		else $error("Underrun not flagged or sample changed");

	und_keep_a: assert property (
		ce_in && s_reg.und[0] && !status_rd |=> s_reg.und[0])
		else $error("Underrun flag cleared without a status read");

	und_clear_a: assert property (
		status_rd && !sample_tick_in[0] |=> !s_reg.und[0])
		else $error("Status read did not clear underrun");

	// A fresh word is taken on a qualified tick unless the channel is clearing
	sample_take_a: assert property (
		ce_in && sample_tick_in[0] && new_data_valid_in[0] && !s_reg.busy[0] |=>
		sample_out[15:0] == $past(new_data_in[15:0]))
		else $error("Offered sample word not taken");

	// Idle is a live level: it falls as soon as the enable is seen and holds otherwise
	idle_live_a: assert property (
		ce_in && s_reg.idle[0] && s_reg.ctrl[`TCS_DIG_A] |=> !s_reg.idle[0])
		else $error("Idle level did not fall on enable");

	idle_hold_a: assert property (
		ce_in && s_reg.idle[1] && !s_reg.ctrl[`TCS_DIG_B] |=> s_reg.idle[1])
		else $error("Idle level fell without an enable");

	// Clearing starts on a starved tick after the enable fell, runs 128 cycles, then idles
	busy_start_a: assert property (
		ce_in && s_reg.st[0] == TCS_DRAIN && !s_reg.ctrl[`TCS_DIG_A] && sample_tick_in[0] &&
		!new_data_valid_in[0] |=> s_reg.busy[0])
		else $error("Data clear did not start after underrun");

	clear_len_a: assert property (
		$rose(s_reg.busy[0]) ##1 ce_in [*8] |-> s_reg.busy[0] && !s_reg.idle[0])
		else $error("Data clear ended too early");

	clear_zero_a: assert property (
		ce_in && s_reg.busy[0] |=> s_reg.sample[0] == 16'h0000)
		else $error("Sample not zeroed while clearing");

	clear_end_a: assert property (
		$fell(s_reg.busy[0]) |-> s_reg.idle[0])
		else $error("Clear finished without idle");

	// Read answers come one cycle later for exactly one cycle; only status reads non-zero
	rd_status_a: assert property (
		status_rd |=> rd_valid_out && rd_data_out[7] == 1'b0 && rd_data_out[3] == 1'b0)
		else $error("Reserved status bits not zero");

	rd_value_a: assert property (
		status_rd |=> rd_data_out == {1'b0, $past(s_reg.ovf[1]), $past(s_reg.und[1]),
		$past(s_reg.idle[1]), 1'b0, $past(s_reg.ovf[0]), $past(s_reg.und[0]),
		$past(s_reg.idle[0])})
		else $error("Status read value does not match the flags");

	rd_zero_a: assert property (
		ce_in && rd_en_in && reg_addr_in != `TCS_OFF_STATUS |=>
		rd_valid_out && rd_data_out == 8'h00)
		else $error("Write-only location read back non-zero");

	rd_pulse_a: assert property (
		ce_in && !rd_en_in |=> !rd_valid_out)
		else $error("Read answer stood longer than one cycle");

	// Gain fields reach the outputs unchanged; the most negative code mutes
	mute_code_a: assert property (
		mute_out[1] == (gain_out[11:6] == `TCS_MUTE_CODE))
		else $error("Mute does not match gain code");

	mute_gain_a: assert property (
		ce_in |=> mute_out[0] == ($past(s_reg.gain[5:0]) == `TCS_MUTE_CODE))
		else $error("Channel A mute does not follow its gain field");

	gain_field_a: assert property (
		ce_in |=> gain_out == {$past(s_reg.gain[13:8]), $past(s_reg.gain[5:0])})
		else $error("Gain fields taken from the wrong bits");

	// Reserved gain and status-enable bits never reach the registers
	mask_gain_a: assert property (
		s_reg.gain[15] == 1'b0 && s_reg.gain[7] == 1'b0)
		else $error("Reserved gain bit stored");

	mask_enable_a: assert property (
		s_reg.stat_en[7] == 1'b0 && s_reg.stat_en[3] == 1'b0)
		else $error("Reserved enable bit stored");

	// Analogue off: clamp set means mid-rail, clamp clear means released; on means driven
	clamp_pin_a: assert property (
		ce_in && !s_reg.ctrl[`TCS_ANA_A] && s_reg.gain[`TCS_CLAMP_A] |=>
		out_midrail_out[0] && out_drive_out[0])
		else $error("Clamped channel not held at mid-rail");

	hiz_pin_a: assert property (
		ce_in && !s_reg.ctrl[`TCS_ANA_A] && !s_reg.gain[`TCS_CLAMP_A] |=>
		!out_drive_out[0] && !out_midrail_out[0])
		else $error("Unclamped disabled channel still driven");

	drive_on_a: assert property (
		ce_in && s_reg.ctrl[`TCS_ANA_B] |=> out_drive_out[1] && !out_midrail_out[1])
		else $error("Enabled channel not driven");

	// Each channel reads the memory its select bit picks, one cycle after the address
	sel_bank_a: assert property (
		ce_in && s_reg.ctrl[`TCS_SEL_B] && $stable(s_reg.ctrl) |=>
		coef_out[31:16] == $past(s_reg.ram1[coef_rd_addr_in[13:7]]))
		else $error("Channel B read wrong coefficient memory");

	sel_bank0_a: assert property (
		ce_in && !s_reg.ctrl[`TCS_SEL_A] |=>
		coef_out[15:0] == $past(s_reg.ram0[coef_rd_addr_in[6:0]]))
		else $error("Channel A read wrong coefficient memory");

	// Summary tracks the enabled flags and drops when nothing is enabled
	summary_a: assert property (
		s_reg.summary == |(s_reg.stat_en & pack_status(s_reg.ovf, s_reg.und, s_reg.idle)))
		else $error("Summary bit disagrees with enabled flags");

	summary_off_a: assert property (
		ce_in && s_reg.stat_en == 8'h00 &&
		!(wr_en_in && reg_addr_in == `TCS_OFF_STAT_EN) |=> !tx_summary_out)
		else $error("Summary raised with every enable low");

	// Main scenarios worth seeing in a run
	stream_c: cover property (ce_in && wr_en_in && reg_addr_in == `TCS_OFF_COEFF0 ##1
		ce_in && wr_en_in && reg_addr_in == `TCS_OFF_COEFF0);
	clear_done_c: cover property ($fell(s_reg.busy[0]) && s_reg.idle[0]);
	summary_c: cover property ($rose(tx_summary_out));
	underrun_c: cover property ($rose(s_reg.und[0]));
	ptr_wrap_c: cover property (ce_in && wr_en_in && reg_addr_in == `TCS_OFF_COEFF0 &&
		s_reg.ptr == 7'h7f);
endmodule

// file: tcs_host.sv
// Purpose: Control-port host model for the transmit register bank.
// Assumes: Requests change on the falling edge; read answer comes one cycle later.
// Notes:   Caller owns coefficient order and pointer set-up.
`timescale 1ns/1ps
module tcs_host (
	input  wire logic        ref_clk_in,
	input  wire logic [7:0]  rd_data_in,
	input  wire logic        rd_valid_in,
	output logic [7:0]       addr_out,
	output logic             wr_en_out,
	output logic [15:0]      wr_data_out,
	output logic             rd_en_out
);
	// Quiet bus from time zero
	initial
	begin
		addr_out = 8'h00;
		wr_en_out = 1'b0;
		wr_data_out = 16'h0000;
		rd_en_out = 1'b0;
	end
	// Strobe stays up so successive calls stream one word a cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] dat);
		@(negedge ref_clk_in);
		addr_out = a;
		wr_data_out = dat;
		wr_en_out = 1'b1;
	endtask
	// Released lines flip so a stale value is never mistaken for data
	task automatic idle();
		@(negedge ref_clk_in);
		wr_en_out = 1'b0;
		wr_data_out = ~wr_data_out;
	endtask
	// Answer taken at the edge where it is valid, or returned unknown
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(negedge ref_clk_in);
		wr_en_out = 1'b0;
		addr_out = a;
		rd_en_out = 1'b1;
		@(negedge ref_clk_in);
		rd_en_out = 1'b0;
		dat = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
	endtask
endmodule

// file: tcs_params.svh
// Purpose: Constants for the transmit coefficient and status register bank.
// Assumes: Register offsets are the byte-wide addresses of the control port.
// Notes:   Channel index 0 is channel A and index 1 is channel B.
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

`define TCS_OFF_CHAN_CTRL   8'h34
`define TCS_OFF_GAIN        8'h35
`define TCS_OFF_COEFF0      8'h36
`define TCS_OFF_COEFF1      8'h37
`define TCS_OFF_POINTER     8'h38
`define TCS_OFF_STATUS      8'h39
`define TCS_OFF_STAT_EN     8'h3a

`define TCS_GAIN_WMASK      16'h7f7f
`define TCS_STAT_EN_WMASK   8'h77
`define TCS_STATUS_RESET    8'h11
`define TCS_MUTE_CODE       6'h20
`define TCS_CLEAR_CYCLES    8'h80
`define TCS_COEFF_DEPTH     128

`define TCS_GAIN_LSB_A      0
`define TCS_GAIN_LSB_B      8
`define TCS_CLAMP_A         6
`define TCS_CLAMP_B         14
`define TCS_SEL_A           0
`define TCS_SEL_B           8
`define TCS_ANA_A           1
`define TCS_ANA_B           9
`define TCS_DIG_A           2
`define TCS_DIG_B           10
`define TCS_STAT_LSB_A      0
`define TCS_STAT_LSB_B      4

`endif

// file: tcs_pkg.sv
// Purpose: Types for the transmit coefficient and status register bank.
// Assumes: Included constants set the memory depth.
// Notes:   All module state lives in one packed struct.
`include "tcs_params.svh"
package tcs_pkg;
	typedef enum logic [1:0] {TCS_IDLE, TCS_RUN, TCS_DRAIN, TCS_CLEAR} tcs_chan_st_t;

	typedef struct packed {
		logic [`TCS_COEFF_DEPTH-1:0][15:0] ram0;
		logic [`TCS_COEFF_DEPTH-1:0][15:0] ram1;
		logic [15:0]                       gain;
		logic [15:0]                       ctrl;
		logic [6:0]                        ptr;
		logic [7:0]                        stat_en;
		logic [1:0]                        ovf;
		logic [1:0]                        und;
		tcs_chan_st_t [1:0]                st;
		logic [1:0][7:0]                   cnt;
		logic [1:0][15:0]                  sample;
		logic [1:0][15:0]                  coef;
		logic [1:0]                        drive;
		logic [1:0]                        midrail;
		logic [1:0][5:0]                   gain_o;
		logic [1:0]                        mute;
		logic [1:0]                        idle;
		logic [1:0]                        busy;
		logic [7:0]                        rd_data;
		logic                              rd_valid;
		logic                              summary;
	} tcs_state_t;
endpackage

// file: testbench.sv
// Purpose: Self-checking bench for the transmit register bank.
// Assumes: Inputs change on the falling edge; outputs settle within two cycles.
// Notes:   Channel A is bit 0 of every per-channel input.
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        ce = 1'b1;
	logic [1:0]  tick = 2'b00;
	logic [1:0]  valid = 2'b00;
	logic [1:0]  sat = 2'b00;
	logic [31:0] ndata = 32'h00000000;
	logic [13:0] craddr = 14'h0000;
	logic [7:0]  addr, rdat, d;
	logic [15:0] wdat;
	logic        wr_en, rd_en, rvld, summ;
	logic [31:0] smp, coef;
	logic [1:0]  drive, mid, mute, busy;
	logic [11:0] gain;
	int          bad_count = 0;
	int          checks = 0;
	int          cycles = 0;
	int          n;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			results();
		end
	end
	tcs_bank dut (.ref_clk_in(clk), .srst_in(srst), .ce_in(ce), .reg_addr_in(addr),
		.wr_en_in(wr_en), .wr_data_in(wdat), .rd_en_in(rd_en), .sample_tick_in(tick),
		.new_data_valid_in(valid), .new_data_in(ndata), .sat_in(sat),
		.coef_rd_addr_in(craddr), .rd_data_out(rdat), .rd_valid_out(rvld), .sample_out(smp),
		.coef_out(coef), .out_drive_out(drive), .out_midrail_out(mid), .gain_out(gain),
		.mute_out(mute), .clear_busy_out(busy), .tx_summary_out(summ));
	tcs_host host (.ref_clk_in(clk), .rd_data_in(rdat), .rd_valid_in(rvld),
		.addr_out(addr), .wr_en_out(wr_en), .wr_data_out(wdat), .rd_en_out(rd_en));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One-cycle channel event, then two cycles for registered outputs
	task automatic pulse(input logic [1:0] tk, input logic [1:0] vl, input logic [1:0] st);
		@(negedge clk);
		{tick, valid, sat} = {tk, vl, st};
		@(negedge clk);
		{tick, valid, sat} = 6'h00;
		repeat (2) @(negedge clk);
	endtask
	task automatic wrs(input logic [7:0] a, input logic [15:0] v);
		host.wr(a, v);
		host.idle();
		repeat (2) @(negedge clk);
	endtask
	task automatic test_gain();
		wrs(8'h35, 16'hffff);
		chk(gain, 12'hfff);
		chk({drive, mid, mute}, 6'h3c);
		// Clock enable low: the write must leave the gain untouched
		ce = 1'b0;
		wrs(8'h35, 16'h0000);
		chk(gain, 12'hfff);
		ce = 1'b1;
		host.wr(8'h35, 16'h2020);
		wrs(8'h34, 16'h0202);
		chk({drive, mid, mute}, 6'h33);
		wrs(8'h35, 16'h162a);
		chk({gain, mute}, {6'h16, 6'h2a, 2'b00});
		wrs(8'h34, 16'h0000);
		chk(drive, 2'b00);
		$display("test_gain done");
	endtask
	// Ratio 2, length 4: memory ends up holding C0 C2 C1 C3
	task automatic test_coeff();
		host.wr(8'h38, 16'h0080);
		for (int i = 0; i < 2; i++)
			for (int j = 0; j < 4; j += 2)
				host.wr(8'h36, 16'ha000 + 16'(i + j));
		host.wr(8'h38, 16'h0000);
		wrs(8'h37, 16'hb000);
		craddr = {7'd1, 7'd2};
		repeat (2) @(negedge clk);
		chk(coef, 32'ha002_a001);
		craddr = {7'd0, 7'd2};
		wrs(8'h34, 16'h0100);
		chk(coef, 32'hb000_a001);
		wrs(8'h34, 16'h0000);
		$display("test_coeff done");
	endtask
	task automatic test_flags();
		host.rd(8'h39, d);
		chk(d, 8'h11);
		host.rd(8'h36, d);
		chk(d, 8'h00);
		host.wr(8'h3a, 16'h00c0);
		wrs(8'h34, 16'h0004);
		chk(summ, 1'b0);
		ndata = 32'h0000_1234;
		pulse(2'b01, 2'b01, 2'b00);
		pulse(2'b01, 2'b00, 2'b10);
		chk({summ, smp[15:0]}, 17'h11234);
		host.rd(8'h39, d);
		chk(d, 8'h52);
		repeat (2) @(negedge clk);
		chk(summ, 1'b0);
		host.rd(8'h39, d);
		chk(d, 8'h10);
		$display("test_flags done");
	endtask
	task automatic test_idle();
		wrs(8'h34, 16'h0000);
		pulse(2'b01, 2'b00, 2'b00);
		chk({busy[0], smp[15:0]}, 17'h10000);
		n = 0;
		while (busy[0] === 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		chk(n + 2, 128);
		host.rd(8'h39, d);
		chk(d, 8'h13);
		$display("test_idle done");
	endtask
	// Reset, then each scenario in turn
	initial
	begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		test_gain();
		test_coeff();
		test_flags();
		test_idle();
		results();
	end
endmodule
